// ---- hw/preload_pkg.sv ----
// Constants shared by the configuration preload block and its leaves.
// Assumes one 200 MHz core clock and an EEPROM word reader outside.
//
// Operation
// - Word 00h holds signature marking valid contents
// - Word 02h loads vendor identifier, ports 0-3
// - Word 04h loads device identifier, ports 0-3
// - Word 06h bits 3:1, 6:4 set exit latencies
// - Word 06h bits 14:8 set switch mode
// - Word 06h bit 15 requests INTA, ports 1-2
// - Word 0Ch bits 2:1 set ASPM support
// - Word 0Ch bit 3 flags role-based error reporting
// - Word 0Ch bits 4,5 disable MSI, AER
// - Word 0Ch bit 6 disables compliance parity control
// - Word 0Ch bit 7 disables power management capability
// - Word 0Ch bit 10 freezes ordering feature
// - Word 0Ch bit 11 selects transmit SOF latency
// - Word 0Ch bit 12 enables surprise-down, ports 1-3
// - Word 0Ch bit 13: writable PM data select
// - Word 0Ch bit 14 selects flow-control update type
// - Word 0Ch bit 15 enables 4KB boundary check
// - Word 0Eh bits 7:0 load revision identifier
// - Word 10h bits 7:0: port 0 FTS count
// - Word 10h bits 9:8: port 0 ppm difference

package preload_pkg;

  // ----------------------------------------------------------------
  // Port counts
  // ----------------------------------------------------------------
  localparam int ALL_PORTS = 4;  // Ports 0..3
  localparam int DN_PORTS  = 3;  // Ports 0..2
  localparam int INT_PORTS = 2;  // Ports 1..2
  localparam int SD_PORTS  = 3;  // Ports 1..3

  // ----------------------------------------------------------------
  // EEPROM word addresses, in fetch order
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SIGNATURE = 8'h00;
  localparam logic [7:0] ADDR_VENDOR    = 8'h02;
  localparam logic [7:0] ADDR_DEVICE    = 8'h04;
  localparam logic [7:0] ADDR_LINKMODE  = 8'h06;
  localparam logic [7:0] ADDR_CAPS      = 8'h0c;
  localparam logic [7:0] ADDR_REVISION  = 8'h0e;
  localparam logic [7:0] ADDR_PHY0      = 8'h10;
  localparam int         WORD_COUNT     = 7;
  localparam logic [2:0] LAST_INDEX     = 3'h6;

  // Index of each word in the fetch sequence
  localparam logic [2:0] IDX_SIGNATURE = 3'h0;
  localparam logic [2:0] IDX_VENDOR    = 3'h1;
  localparam logic [2:0] IDX_DEVICE    = 3'h2;
  localparam logic [2:0] IDX_LINKMODE  = 3'h3;
  localparam logic [2:0] IDX_CAPS      = 3'h4;
  localparam logic [2:0] IDX_REVISION  = 3'h5;
  localparam logic [2:0] IDX_PHY0      = 3'h6;

  // ----------------------------------------------------------------
  // Source bit positions inside the EEPROM words
  // ----------------------------------------------------------------
  localparam int LM_L0S_LSB = 1;   // Word 06h, 3 bits
  localparam int LM_L1_LSB  = 4;   // Word 06h, 3 bits
  localparam int LM_EGRESS  = 8;
  localparam int LM_CPLTAG  = 9;
  localparam int LM_SAF     = 10;
  localparam int LM_CT_LSB  = 11;  // 2 bits
  localparam int LM_ARB     = 13;
  localparam int LM_CREDIT  = 14;
  localparam int LM_INTA    = 15;
  localparam int CP_MPS     = 0;
  localparam int CP_ASPM_LSB = 1;  // 2 bits
  localparam int CP_RBER    = 3;
  localparam int CP_MSI_DIS = 4;
  localparam int CP_AER_DIS = 5;
  localparam int CP_PAR_DIS = 6;
  localparam int CP_PM_DIS  = 7;
  localparam int CP_FREEZE  = 10;
  localparam int CP_SOF     = 11;
  localparam int CP_SDOWN   = 12;
  localparam int CP_PMDS_RW = 13;
  localparam int CP_FC_TYPE = 14;
  localparam int CP_4KB     = 15;
  localparam int PH_PPM_LSB = 8;   // Word 10h, 2 bits

  // ----------------------------------------------------------------
  // Hardware defaults kept when no valid image is present
  // ----------------------------------------------------------------
  localparam logic [15:0] DEF_VENDOR_ID = 16'h0a5a;  // Arbitrary value
  localparam logic [15:0] DEF_DEVICE_ID = 16'h0c3c;  // Arbitrary value
  localparam logic [7:0]  DEF_REVISION  = 8'h00;     // Arbitrary value
  localparam logic [15:0] DEF_SIGNATURE = 16'h5aa5;  // Arbitrary value

endpackage : preload_pkg

// ---- hw/cfg_field.sv ----
// One preloaded configuration field, replicated over its ports.
// Assumes the loader raises load for one cycle with the full image.
`timescale 1ns/100ps

module cfg_field #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] q
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Hardware default until a load; held until the next load or reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= RESET_VAL;
    end else if (load) begin
      q <= din;
    end
  end

endmodule // cfg_field

// ---- hw/eeprom_word_fetch.sv ----
// Requests one EEPROM word at a time from the serial reader outside.
// Assumes the reader answers every request with one valid pulse.
`timescale 1ns/100ps

module eeprom_word_fetch (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,      // One-cycle launch
  input  wire logic [7:0]  addr,       // Word address to read
  input  wire logic        rd_valid,   // Reader answer strobe
  input  wire logic [15:0] rd_data,    // Reader answer word
  output logic             rd_req,     // Held until answered
  output logic      [7:0]  rd_addr,    // Stable while rd_req high
  output logic             done,       // One-cycle, word in data
  output logic      [15:0] data        // Last word captured
);

  // ----------------------------------------------------------------
  // Request handshake
  // ----------------------------------------------------------------
  // A valid outside a request is ignored so a stray strobe loads nothing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_req  <= 1'b0;
      rd_addr <= 8'h00;
    end else if (start) begin
      rd_req  <= 1'b1;
      rd_addr <= addr;
    end else if (rd_req && rd_valid) begin
      rd_req  <= 1'b0;
    end
  end

  // Capture the answer and flag it for one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done <= 1'b0;
      data <= 16'h0000;
    end else begin
      done <= rd_req && rd_valid;
      if (rd_req && rd_valid) begin
        data <= rd_data;
      end
    end
  end

endmodule // eeprom_word_fetch

// ---- hw/eeprom_config_preload.sv ----
// Walks the EEPROM image after reset and loads configuration fields.
// Assumes an outside reader that turns word requests into serial reads.
`timescale 1ns/100ps

module eeprom_config_preload
  import preload_pkg::*;
#(
  parameter logic [15:0] SIGNATURE = DEF_SIGNATURE  // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // EEPROM word reader
  input  wire logic        ee_rd_valid,
  input  wire logic [15:0] ee_rd_data,
  output logic             ee_rd_req,
  output logic      [7:0]  ee_rd_addr,
  // Preload status
  output logic             preload_busy,
  output logic             preload_done,
  output logic             signature_ok,
  // Identity, 16 bits per port 0..3 (revision 8 bits), port 0 lowest
  output logic      [63:0] vendor_id,
  output logic      [63:0] device_id,
  output logic      [31:0] revision_id,
  // Link capability, ports 0..2
  output logic      [8:0]  l0s_exit_latency,
  output logic      [8:0]  l1_exit_latency,
  // Switch mode image, 7 bits per port 0..2
  output logic      [20:0] switch_mode,
  // Interrupt pin request, ports 1..2
  output logic      [1:0]  inta_request,
  // Capability options, one bit per port 0..3; ASPM two bits per port, surprise-down ports 1..3 only
  output logic      [3:0]  max_payload_support,
  output logic      [7:0]  aspm_support,
  output logic      [3:0]  role_err_report,
  output logic      [3:0]  msi_disable,
  output logic      [3:0]  aer_disable,
  output logic      [3:0]  parity_ctl_disable,
  output logic      [3:0]  pm_cap_disable,
  output logic      [3:0]  ordering_frozen,
  output logic      [3:0]  sof_latency_mode,
  output logic      [2:0]  surprise_down_cap,
  output logic      [3:0]  pm_data_sel_rw,
  output logic      [3:0]  fc_update_type,
  output logic      [3:0]  boundary_4kb_check,
  // Port 0 physical layer
  output logic      [7:0]  fts_count_p0,
  output logic      [1:0]  refclk_ppm_p0
);

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_LAUNCH = 3'b001,  // Issue the next word request
    ST_WAIT   = 3'b010,  // Wait for the word to arrive
    ST_DONE   = 3'b100   // Preload over, fields frozen
  } seq_state_type;

  seq_state_type state;      // Current sequencer state
  logic [2:0]    word_idx;   // Position in the fetch list
  logic          fetch_done; // Word ready this cycle
  logic [15:0]   word;       // Word just fetched
  logic          launch;     // Start pulse to the fetcher
  logic [7:0]    word_addr;  // Address for the current index
  logic          sig_match;  // Signature word is good
  logic          take;       // Current word may be applied
  logic [WORD_COUNT-1:0] load;  // One load strobe per word

  // ----------------------------------------------------------------
  // Fetch list
  // ----------------------------------------------------------------
  // Only the words this block consumes are read, to keep boot short
  always_comb begin
    unique case (word_idx)
      IDX_SIGNATURE: word_addr = ADDR_SIGNATURE;
      IDX_VENDOR:    word_addr = ADDR_VENDOR;
      IDX_DEVICE:    word_addr = ADDR_DEVICE;
      IDX_LINKMODE:  word_addr = ADDR_LINKMODE;
      IDX_CAPS:      word_addr = ADDR_CAPS;
      IDX_REVISION:  word_addr = ADDR_REVISION;
      IDX_PHY0:      word_addr = ADDR_PHY0;
      default:       word_addr = ADDR_SIGNATURE;  // Index 7 unused
    endcase
  end

  // One pulse per word; the fetcher holds its request
  assign launch    = (state == ST_LAUNCH);
  // Judged on the captured word, never on the pins
  assign sig_match = (word == SIGNATURE);
  // Words after the signature apply only once it matched
  assign take      = (state == ST_WAIT) && fetch_done;

  // One-hot load strobes; the signature itself loads nothing
  always_comb begin
    load = '0;
    if (take && word_idx != IDX_SIGNATURE && signature_ok) begin
      load[word_idx] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Word fetcher
  // ----------------------------------------------------------------
  eeprom_word_fetch u_fetch (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (launch),
    .addr     (word_addr),
    .rd_valid (ee_rd_valid),
    .rd_data  (ee_rd_data),
    .rd_req   (ee_rd_req),
    .rd_addr  (ee_rd_addr),
    .done     (fetch_done),
    .data     (word)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Runs once per reset; no way to restart without a reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= ST_LAUNCH;
      word_idx <= IDX_SIGNATURE;
    end else begin
      unique case (state)
        ST_LAUNCH: begin
          // Request goes out on this same edge
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          // A slow reader only stretches the boot time
          if (fetch_done) begin
            if (word_idx == IDX_SIGNATURE && !sig_match) begin
              state <= ST_DONE;
            end else if (word_idx == LAST_INDEX) begin
              state <= ST_DONE;
            end else begin
              state    <= ST_LAUNCH;
              word_idx <= word_idx + 3'h1;
            end
          end
        end
        ST_DONE: begin
          state <= ST_DONE;  // Held until the next reset
        end
        default: begin
          state <= ST_DONE;  // Illegal code: stop with defaults kept
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Signature verdict, kept for software to see
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      signature_ok <= 1'b0;
    end else if (take && word_idx == IDX_SIGNATURE) begin
      signature_ok <= sig_match;
    end
  end

  // Config access is held off while busy and opened by done
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      preload_busy <= 1'b1;
      preload_done <= 1'b0;
    end else if (take && (word_idx == LAST_INDEX ||
                          (word_idx == IDX_SIGNATURE && !sig_match))) begin
      // Last word applied, or the image was refused
      preload_busy <= 1'b0;
      preload_done <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Identity words
  // ----------------------------------------------------------------
  // Each identity word is copied to all four ports; revision takes only bits 7:0
  cfg_field #(.WIDTH(64), .RESET_VAL({ALL_PORTS{DEF_VENDOR_ID}})) u_vid (
    .clk(clk), .rst_n(rst_n),
    .load(load[IDX_VENDOR]),
    .din({ALL_PORTS{word}}), .q(vendor_id)
  );
  cfg_field #(.WIDTH(64), .RESET_VAL({ALL_PORTS{DEF_DEVICE_ID}})) u_did (
    .clk(clk), .rst_n(rst_n),
    .load(load[IDX_DEVICE]),
    .din({ALL_PORTS{word}}), .q(device_id)
  );
  cfg_field #(.WIDTH(32), .RESET_VAL({ALL_PORTS{DEF_REVISION}})) u_rev (
    .clk(clk), .rst_n(rst_n),
    .load(load[IDX_REVISION]),
    .din({ALL_PORTS{word[7:0]}}), .q(revision_id)
  );

  // ----------------------------------------------------------------
  // Link and switch mode word
  // ----------------------------------------------------------------
  // Exit latencies reach ports 0..2 only
  cfg_field #(.WIDTH(9)) u_l0s (
    .clk(clk), .rst_n(rst_n),
    .load(load[IDX_LINKMODE]),
    .din({DN_PORTS{word[LM_L0S_LSB +: 3]}}), .q(l0s_exit_latency)
  );
  cfg_field #(.WIDTH(9)) u_l1 (
    .clk(clk), .rst_n(rst_n),
    .load(load[IDX_LINKMODE]),
    .din({DN_PORTS{word[LM_L1_LSB +: 3]}}), .q(l1_exit_latency)
  );
  // Image bits: 6 tag, 5 egress, 4 credit, 3 arb, 2:1 cut, 0 SAF
  cfg_field #(.WIDTH(21)) u_swm (
    .clk(clk), .rst_n(rst_n),
    .load(load[IDX_LINKMODE]),
    .din({DN_PORTS{word[LM_CPLTAG], word[LM_EGRESS], word[LM_CREDIT],
                   word[LM_ARB], word[LM_CT_LSB +: 2], word[LM_SAF]}}),
    .q(switch_mode)
  );
  // Only ports 1 and 2 own an interrupt pin
  cfg_field #(.WIDTH(2)) u_inta (
    .clk(clk), .rst_n(rst_n),
    .load(load[IDX_LINKMODE]),
    .din({INT_PORTS{word[LM_INTA]}}), .q(inta_request)
  );

  // ----------------------------------------------------------------
  // Capability option word
  // ----------------------------------------------------------------
  // Every option bit is replicated to ports 0..3, except surprise-down to ports 1..3
  cfg_field #(.WIDTH(4)) u_mps (
    .clk(clk), .rst_n(rst_n), .load(load[IDX_CAPS]),
    .din({ALL_PORTS{word[CP_MPS]}}), .q(max_payload_support)
  );
  cfg_field #(.WIDTH(8)) u_aspm (
    .clk(clk), .rst_n(rst_n), .load(load[IDX_CAPS]),
    .din({ALL_PORTS{word[CP_ASPM_LSB +: 2]}}), .q(aspm_support)
  );
  cfg_field #(.WIDTH(4)) u_rber (
    .clk(clk), .rst_n(rst_n), .load(load[IDX_CAPS]),
    .din({ALL_PORTS{word[CP_RBER]}}), .q(role_err_report)
  );
  cfg_field #(.WIDTH(4)) u_msi (
    .clk(clk), .rst_n(rst_n), .load(load[IDX_CAPS]),
    .din({ALL_PORTS{word[CP_MSI_DIS]}}), .q(msi_disable)
  );
  cfg_field #(.WIDTH(4)) u_aer (
    .clk(clk), .rst_n(rst_n), .load(load[IDX_CAPS]),
    .din({ALL_PORTS{word[CP_AER_DIS]}}), .q(aer_disable)
  );
  cfg_field #(.WIDTH(4)) u_par (
    .clk(clk), .rst_n(rst_n), .load(load[IDX_CAPS]),
    .din({ALL_PORTS{word[CP_PAR_DIS]}}), .q(parity_ctl_disable)
  );
  cfg_field #(.WIDTH(4)) u_pmd (
    .clk(clk), .rst_n(rst_n), .load(load[IDX_CAPS]),
    .din({ALL_PORTS{word[CP_PM_DIS]}}), .q(pm_cap_disable)
  );
  cfg_field #(.WIDTH(4)) u_frz (
    .clk(clk), .rst_n(rst_n), .load(load[IDX_CAPS]),
    .din({ALL_PORTS{word[CP_FREEZE]}}), .q(ordering_frozen)
  );
  // Zero picks the shorter start-of-frame latency
  cfg_field #(.WIDTH(4)) u_sof (
    .clk(clk), .rst_n(rst_n), .load(load[IDX_CAPS]),
    .din({ALL_PORTS{word[CP_SOF]}}), .q(sof_latency_mode)
  );
  // Port 0 is the upstream side and never reports surprise-down
  cfg_field #(.WIDTH(3)) u_sdn (
    .clk(clk), .rst_n(rst_n), .load(load[IDX_CAPS]),
    .din({SD_PORTS{word[CP_SDOWN]}}), .q(surprise_down_cap)
  );
  cfg_field #(.WIDTH(4)) u_pmds (
    .clk(clk), .rst_n(rst_n), .load(load[IDX_CAPS]),
    .din({ALL_PORTS{word[CP_PMDS_RW]}}), .q(pm_data_sel_rw)
  );
  cfg_field #(.WIDTH(4)) u_fct (
    .clk(clk), .rst_n(rst_n), .load(load[IDX_CAPS]),
    .din({ALL_PORTS{word[CP_FC_TYPE]}}), .q(fc_update_type)
  );
  cfg_field #(.WIDTH(4)) u_4kb (
    .clk(clk), .rst_n(rst_n), .load(load[IDX_CAPS]),
    .din({ALL_PORTS{word[CP_4KB]}}), .q(boundary_4kb_check)
  );

  // ----------------------------------------------------------------
  // Port 0 physical layer word
  // ----------------------------------------------------------------
  // Receiver-side FTS count, port 0 only
  cfg_field #(.WIDTH(8)) u_fts (
    .clk(clk), .rst_n(rst_n),
    .load(load[IDX_PHY0]),
    .din(word[7:0]), .q(fts_count_p0)
  );
  // Codes 0..3 stand for 0, 100, 200 and 300 ppm
  cfg_field #(.WIDTH(2)) u_ppm (
    .clk(clk), .rst_n(rst_n),
    .load(load[IDX_PHY0]),
    .din(word[PH_PPM_LSB +: 2]), .q(refclk_ppm_p0)
  );

endmodule // eeprom_config_preload

// ---- tb/preload_asserts.sv ----
// Concurrent checks on the preload block, seen only through its ports.
// Assumes the shared package and one clock with synchronous reset.
`timescale 1ns/100ps

module preload_asserts
  import preload_pkg::*;
#(
  parameter logic [15:0] SIGNATURE = DEF_SIGNATURE  // Arbitrary value
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ee_rd_valid,
  input wire logic [15:0] ee_rd_data,
  input wire logic        ee_rd_req,
  input wire logic [7:0]  ee_rd_addr,
  input wire logic        preload_busy,
  input wire logic        preload_done,
  input wire logic        signature_ok,
  input wire logic [63:0] vendor_id,
  input wire logic [31:0] revision_id,
  input wire logic [7:0]  fts_count_p0,
  input wire logic [1:0]  refclk_ppm_p0
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [7:0]  exp_addr;  // Address the next request must carry
  logic [15:0] vend_w;    // Answered vendor word
  logic [15:0] rev_w;     // Answered revision word
  logic [15:0] phy_w;     // Answered port 0 physical word
  logic        ans;       // Answer taken at this edge

  assign ans = ee_rd_req && ee_rd_valid;

  // Own copy of the fetch order, so a skipped word shows up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exp_addr <= 8'h00;
    end else if (ans) begin
      exp_addr <= (exp_addr == 8'h06) ? 8'h0c : exp_addr + 8'h02;
    end
  end

  // Words as the reader answered them
  always_ff @(posedge clk) begin
    if (ans && ee_rd_addr == 8'h02) vend_w <= ee_rd_data;
    if (ans && ee_rd_addr == 8'h0e) rev_w <= ee_rd_data;
    if (ans && ee_rd_addr == 8'h10) phy_w <= ee_rd_data;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_req_held: assert property (ee_rd_req && !ee_rd_valid |=>
    ee_rd_req && $stable(ee_rd_addr)) else $error("request dropped");
  a_req_drop: assert property (ans |=> !ee_rd_req)
    else $error("request kept after answer");
  a_addr_order: assert property (ee_rd_req |-> ee_rd_addr == exp_addr)
    else $error("word address out of order");
  a_next_spacing: assert property (ans && exp_addr != 8'h10 &&
    (exp_addr != 8'h00 || ee_rd_data == SIGNATURE) |=>
    !ee_rd_req ##[1:3] ee_rd_req) else $error("next request late");
  a_busy_done: assert property (preload_done == !preload_busy)
    else $error("busy and done disagree");
  a_idle_after: assert property (preload_done |-> !ee_rd_req)
    else $error("request after preload end");
  a_bad_skip: assert property (ans && exp_addr == 8'h00 &&
    ee_rd_data != SIGNATURE |-> ##[1:3] (preload_done && !signature_ok))
    else $error("bad signature not skipped");
  a_bad_default: assert property (preload_done && !signature_ok |->
    vendor_id == {4{DEF_VENDOR_ID}} && fts_count_p0 == 8'h00)
    else $error("defaults lost after skip");
  a_good_finish: assert property (ans && exp_addr == 8'h10 |->
    ##[1:3] (preload_done && signature_ok)) else $error("no finish");
  a_copy_fields: assert property ($rose(preload_done)
    && signature_ok |-> vendor_id == {4{vend_w}} &&
    revision_id == {4{rev_w[7:0]}} &&
    fts_count_p0 == phy_w[7:0] && refclk_ppm_p0 == phy_w[9:8])
    else $error("loaded fields differ from image");
  a_fields_hold: assert property (preload_done |=> $stable(vendor_id)
    && $stable(fts_count_p0)) else $error("field moved after load");

  c_good: cover property ($rose(preload_done) && signature_ok);
  c_bad: cover property ($rose(preload_done) && !signature_ok);
  c_slow: cover property ((ee_rd_req && !ee_rd_valid) [*3]);
endmodule // preload_asserts

bind eeprom_config_preload preload_asserts #(.SIGNATURE(SIGNATURE)) chk_i (
  .clk(clk), .rst_n(rst_n), .ee_rd_valid(ee_rd_valid),
  .ee_rd_data(ee_rd_data), .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr),
  .preload_busy(preload_busy), .preload_done(preload_done),
  .signature_ok(signature_ok), .vendor_id(vendor_id),
  .revision_id(revision_id), .fts_count_p0(fts_count_p0),
  .refclk_ppm_p0(refclk_ppm_p0));

// ---- tb/eeprom_model.sv ----
// Behavioural EEPROM word reader holding a configuration image.
// Assumes requests are held until answered; answers after a set wait.
`timescale 1ns/100ps

module eeprom_model (
  input wire logic       clk,
  input wire logic       req,          // Word request from the block
  input wire logic [7:0] addr,         // Byte address of the word
  input wire logic [3:0] wait_cycles,  // Edges to wait before answering
  output logic           valid,        // One-cycle answer strobe
  output logic    [15:0] data          // Answered word
);
  logic [15:0] mem [0:127];  // Image, word 00h holds the signature
  logic [7:0]  seen [$];     // Addresses answered, in order
  logic [3:0]  cnt;          // Wait counter

  initial begin
    valid = 1'b0;
    data = 16'h0000;
    cnt = 4'h0;
  end

  // ----------------------------------------------------------------
  // Answer engine, moves just after each rising edge
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    #1;
    if (valid) begin
      // Data no longer valid: show the inverse, not a stale word
      valid = 1'b0;
      data = ~data;
    end else if (req && cnt == wait_cycles) begin
      valid = 1'b1;
      data = mem[addr[7:1]];
      seen.push_back(addr);
      cnt = 4'h0;
    end else begin
      if (req) cnt = cnt + 4'h1;
      data = ~data;
    end
  end
endmodule // eeprom_model

// ---- tb/eeprom_config_preload_bench.sv ----
// Testbench for the configuration preload block with an EEPROM model.
// Assumes the design package; three loads: fast, slow, bad signature.
`timescale 1ns/100ps

module eeprom_config_preload_bench;
  import preload_pkg::*;
  logic        clk, rst_n, ee_rd_valid, ee_rd_req;
  logic        preload_busy, preload_done, signature_ok;
  logic [15:0] ee_rd_data;
  logic [7:0]  ee_rd_addr, fts_count_p0, aspm_support;
  logic [63:0] vendor_id, device_id;
  logic [31:0] revision_id;
  logic [8:0]  l0s_exit_latency, l1_exit_latency;
  logic [20:0] switch_mode;
  logic [1:0]  inta_request, refclk_ppm_p0;
  logic [2:0]  surprise_down_cap;
  logic [3:0]  mps, rber, msi, aer, par, pmd, frz, sof, pmds, fct, b4k;
  logic [3:0]  wait_cycles;  // Reader answer delay
  logic [15:0] img [7];      // Image words in fetch order
  logic [7:0]  at [7] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h0c, 8'h0e, 8'h10};
  int          errors = 0, cmp_count = 0;

  eeprom_config_preload uut (.clk(clk), .rst_n(rst_n),
    .ee_rd_valid(ee_rd_valid), .ee_rd_data(ee_rd_data),
    .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr),
    .preload_busy(preload_busy), .preload_done(preload_done),
    .signature_ok(signature_ok), .vendor_id(vendor_id),
    .device_id(device_id), .revision_id(revision_id),
    .l0s_exit_latency(l0s_exit_latency), .l1_exit_latency(l1_exit_latency),
    .switch_mode(switch_mode), .inta_request(inta_request),
    .max_payload_support(mps), .aspm_support(aspm_support),
    .role_err_report(rber), .msi_disable(msi), .aer_disable(aer),
    .parity_ctl_disable(par), .pm_cap_disable(pmd), .ordering_frozen(frz),
    .sof_latency_mode(sof), .surprise_down_cap(surprise_down_cap),
    .pm_data_sel_rw(pmds), .fc_update_type(fct), .boundary_4kb_check(b4k),
    .fts_count_p0(fts_count_p0), .refclk_ppm_p0(refclk_ppm_p0));

  eeprom_model model (.clk(clk), .req(ee_rd_req), .addr(ee_rd_addr),
    .wait_cycles(wait_cycles), .valid(ee_rd_valid), .data(ee_rd_data));

  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Compare and close
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One preload: reset for two edges, wait for the end, check all
  task automatic run(input logic [3:0] dly);
    logic [15:0] e [7];
    logic        good;
    int          n;
    wait_cycles = dly;
    model.seen.delete();
    foreach (img[i]) model.mem[at[i][7:1]] = img[i];
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk);
    #1 chk(preload_busy, 1'b1);
    chk(preload_done, 1'b0);
    n = 0;
    while (preload_done !== 1'b1 && n < 500) begin
      @(posedge clk);
      #1 n++;
    end
    good = (img[0] === DEF_SIGNATURE);
    e = img;
    // A refused image must leave every field at its default
    if (!good) e = '{16'h0, DEF_VENDOR_ID, DEF_DEVICE_ID, 16'h0, 16'h0,
                     {8'h00, DEF_REVISION}, 16'h0};
    chk(signature_ok, good);
    chk(preload_busy, 1'b0);
    chk(model.seen.size(), good ? 7 : 1);
    foreach (model.seen[i]) chk(model.seen[i], at[i]);
    chk(vendor_id, {4{e[1]}});
    chk(device_id, {4{e[2]}});
    chk(l0s_exit_latency, {3{e[3][3:1]}});
    chk(l1_exit_latency, {3{e[3][6:4]}});
    chk(switch_mode, {3{e[3][9:8], e[3][14:13], e[3][12:10]}});
    chk(inta_request, {2{e[3][15]}});
    chk({mps, rber, msi, aer}, {{4{e[4][0]}}, {4{e[4][3]}},
                                {4{e[4][4]}}, {4{e[4][5]}}});
    chk(aspm_support, {4{e[4][2:1]}});
    chk({par, pmd, frz, sof}, {{4{e[4][6]}}, {4{e[4][7]}},
                               {4{e[4][10]}}, {4{e[4][11]}}});
    chk(surprise_down_cap, {3{e[4][12]}});
    chk({pmds, fct, b4k}, {{4{e[4][13]}}, {4{e[4][14]}},
                           {4{e[4][15]}}});
    chk(revision_id, {4{e[5][7:0]}});
    chk(fts_count_p0, e[6][7:0]);
    chk(refclk_ppm_p0, e[6][9:8]);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    wait_cycles = 4'h0;
    img = '{DEF_SIGNATURE, 16'h1234, 16'h9abc, 16'h5a69, 16'hc3a5,
            16'h0077, 16'h02d4};
    run(4'h0);
    // Complement every data word so each field bit sees both levels
    for (int i = 1; i < 7; i++) img[i] = ~img[i];
    run(4'h5);
    img[0] = ~DEF_SIGNATURE;
    run(4'h1);
    complete_run();
  end

  initial begin
    #50000;
    errors++;
    complete_run();
  end
endmodule // eeprom_config_preload_bench
